// *** rtl/adcrst_top.sv ***
`timescale 1ns/10ps
`default_nettype none

// How it works
// (RQ1) Reset comes from power-up (rst_n_i) or from writing soft_reset_bit of the config word.
// (RQ2) Both sources merge into one internal reset and either alone is enough.
// (RQ3) Any reset loads config, both shifters, cfg_valid and ones_frame with ones; state, bitcnt and soft_req load zero.
// (RQ4) The first serial frame after any reset shifts out all ones instead of a result.
// (RQ5) Any reset returns the control state machine to its power-on state.
// (RQ6) After a supply dip between 125mV and 400mV the host must issue a software reset.
// (RQ7) Serial data is driven only while frame_sync_select_n is low; its rise floats the pin.
module adcrst_top
  import adcrst_pkg::*;
(
  // ------------------------------------------------------------
  // Clock and power-on reset
  // ------------------------------------------------------------
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // ------------------------------------------------------------
  // Serial link, sampled on ref_clk_i
  // ------------------------------------------------------------
  input  wire logic                frame_sync_select_n_i,
  input  wire logic                sclk_rise_i,
  input  wire logic                sdi_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  // ------------------------------------------------------------
  // Converter core side
  // ------------------------------------------------------------
  input  wire logic [WORD_W-1:0]   result_i,
  input  wire logic                result_valid_i,
  // ------------------------------------------------------------
  // Configuration and status
  // ------------------------------------------------------------
  output logic [CFG_W-1:0]         config_register_o,
  output logic                     config_valid_o,
  output logic                     internal_reset_o,
  output logic                     busy_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // One struct, so a reset loads every bit in one assignment
  typedef struct packed {
    adcrst_state_t           state;
    logic [CFG_W-1:0]        cfg;
    logic                    cfg_valid;
    logic [WORD_W-1:0]       shift_in;
    logic [WORD_W-1:0]       shift_out;
    logic [BITCNT_W-1:0]     bitcnt;
    logic                    ones_frame;
    logic                    fs_n_d;
    logic                    soft_req;
  } adcrst_regs_t;

  localparam adcrst_regs_t REGS_RESET = '{
    state:      ADCRST_POWER_ON,
    cfg:        CFG_RESET,
    cfg_valid:  1'b1,
    shift_in:   SHIFT_RESET,
    shift_out:  SHIFT_RESET,
    bitcnt:     BITCNT_RESET,
    ones_frame: 1'b1,
    fs_n_d:     1'b1,
    soft_req:   1'b0
  };

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Both shifters move MSB first, new bit at the low end
  function automatic logic [WORD_W-1:0] shift_word(
    input logic [WORD_W-1:0] w,
    input logic              b
  );
    return {w[WORD_W-2:0], b};
  endfunction

  // Stops at a full word, so a long frame still counts as complete
  function automatic logic [BITCNT_W-1:0] count_step(
    input logic [BITCNT_W-1:0] c
  );
    logic [BITCNT_W-1:0] n;
    n = c;
    if (c != BITCNT_FULL)
    begin
      n = c + 5'h01;
    end
    return n;
  endfunction

  // The low bits received last form the config word
  function automatic logic [CFG_W-1:0] cfg_field(
    input logic [WORD_W-1:0] w
  );
    return w[CFG_W-1:0];
  endfunction

  function automatic logic is_busy(
    input adcrst_state_t s
  );
    return (s == ADCRST_BUSY);
  endfunction

  function automatic logic is_power_on(
    input adcrst_state_t s
  );
    return (s == ADCRST_POWER_ON);
  endfunction

  // ------------------------------------------------------------
  // Registers and frame edges
  // ------------------------------------------------------------
  adcrst_regs_t r_r;
  adcrst_regs_t r_nxt;
  logic         frame_start;
  logic         frame_end;
  logic         in_frame;

  assign in_frame    = ~frame_sync_select_n_i;
  // A select that falls in the power-on cycle is never seen as a start
  assign frame_start = r_r.fs_n_d & ~frame_sync_select_n_i;
  assign frame_end   = ~r_r.fs_n_d & frame_sync_select_n_i;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    r_nxt          = r_r;
    r_nxt.fs_n_d   = frame_sync_select_n_i;
    r_nxt.soft_req = 1'b0;
    unique case (r_r.state)
      ADCRST_POWER_ON:
      begin
        r_nxt.state = ADCRST_IDLE;
      end
      ADCRST_IDLE:
      begin
        if (frame_start)
        begin
          r_nxt.state  = ADCRST_BUSY;
          r_nxt.bitcnt = BITCNT_RESET;
          // (RQ4) ones frame
          r_nxt.shift_out = r_r.ones_frame ? SHIFT_RESET : result_i;
        end
        else if (result_valid_i && !r_r.ones_frame)
        begin
          r_nxt.shift_out = result_i;
        end
      end
      ADCRST_BUSY:
      begin
        if (frame_end)
        begin
          r_nxt.state      = ADCRST_IDLE;
          r_nxt.ones_frame = 1'b0;
          // Short frames write nothing
          if (r_r.bitcnt >= BITCNT_FULL)
          begin
            r_nxt.cfg       = cfg_field(r_r.shift_in);
            r_nxt.cfg_valid = 1'b1;
            // Acts next cycle, so the written word shows for one cycle
            // (RQ1) software reset bit
            r_nxt.soft_req  = r_r.shift_in[SOFT_RESET_POS];
          end
        end
        else if (in_frame && sclk_rise_i)
        begin
          r_nxt.shift_in  = shift_word(r_r.shift_in, sdi_i);
          r_nxt.shift_out = shift_word(r_r.shift_out, 1'b1);
          r_nxt.bitcnt    = count_step(r_r.bitcnt);
        end
      end
      default:
      begin
        r_nxt.state = ADCRST_POWER_ON;
      end
    endcase
    // Overrides all above, so a frame in flight is abandoned
    // (RQ2) merged reset
    if (r_r.soft_req)
    begin
      // (RQ3) ones in config and shifters, zero state and count
      r_nxt        = REGS_RESET;
      // (RQ5) power-on state
      r_nxt.state  = ADCRST_POWER_ON;
      // Keep tracking the pin so no false start follows
      r_nxt.fs_n_d = frame_sync_select_n_i;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r_r <= REGS_RESET;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Combinational, so the pin floats in the cycle the select rises
  // (RQ7) drive only in frame
  assign sdo_oe_o          = in_frame && is_busy(r_r.state);
  assign sdo_o             = r_r.shift_out[WORD_W-1];
  assign config_register_o = r_r.cfg;
  assign config_valid_o    = r_r.cfg_valid;
  assign internal_reset_o  = r_r.soft_req || is_power_on(r_r.state);
  assign busy_o            = is_busy(r_r.state);

endmodule // adcrst_top

`default_nettype wire

// *** rtl/adcrst_pkg.sv ***
`default_nettype none

package adcrst_pkg;

  // ------------------------------------------------------------
  // Widths and field positions
  // ------------------------------------------------------------
  localparam int unsigned CFG_W          = 12;
  localparam int unsigned SOFT_RESET_POS = 0;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned BITCNT_W       = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [CFG_W-1:0]    CFG_RESET    = 12'hFFF;
  localparam logic [WORD_W-1:0]   SHIFT_RESET  = 16'hFFFF;
  localparam logic [BITCNT_W-1:0] BITCNT_RESET = 5'h00;
  localparam logic [BITCNT_W-1:0] BITCNT_FULL  = 5'h10;

  // ------------------------------------------------------------
  // Control state machine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCRST_POWER_ON = 2'b00,
    ADCRST_IDLE     = 2'b01,
    ADCRST_BUSY     = 2'b11
  } adcrst_state_t;

endpackage : adcrst_pkg

`default_nettype wire

// *** sim/adcrst_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrst_sva
  import adcrst_pkg::*;
(
  input wire logic             ref_clk_i, rst_n_i, frame_sync_select_n_i, sclk_rise_i,
  input wire logic             sdo_o, sdo_oe_o, internal_reset_o, busy_o,
  input wire logic [CFG_W-1:0] config_register_o
);
  // Armed by any reset, cleared once the first frame closes
  logic first_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) first_r <= 1'b1;
    else if (internal_reset_o) first_r <= 1'b1;
    else if ($fell(sdo_oe_o)) first_r <= 1'b0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence frm_start;
    $fell(frame_sync_select_n_i) && !busy_o && !internal_reset_o;
  endsequence
  a_oe_frame_low: assert property (sdo_oe_o |-> !frame_sync_select_n_i)
    else $error("sdo driven outside frame");
  a_oe_answer: assert property (frm_start |=> sdo_oe_o)
    else $error("sdo not driven after frame start");
  a_sdo_hold: assert property (sdo_oe_o && !sclk_rise_i ##1 sdo_oe_o |-> $stable(sdo_o))
    else $error("sdo moved without strobe");
  a_first_ones: assert property (sdo_oe_o && first_r |-> sdo_o)
    else $error("first frame bit not one");
  a_por_ones: assert property ($rose(rst_n_i) |-> config_register_o == CFG_RESET && internal_reset_o)
    else $error("power-on defaults wrong");
  a_soft_ones: assert property ($rose(internal_reset_o) |-> ##[0:2] config_register_o == CFG_RESET)
    else $error("soft reset defaults wrong");
  a_reset_idle: assert property (internal_reset_o |-> !busy_o && !sdo_oe_o)
    else $error("activity under reset");
  a_cfg_cause: assert property ($changed(config_register_o) |-> $past(busy_o) || $past(internal_reset_o) || $past(internal_reset_o, 2))
    else $error("config changed without cause");
endmodule // adcrst_sva
bind adcrst_top adcrst_sva adcrst_sva_inst (.*);
`default_nettype wire

// *** sim/adcrst_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrst_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      fs_n_o, sclk_o, sdi_o
);
  initial {fs_n_o, sclk_o, sdi_o} = 3'h4;
  // MSB first; released data line toggles so no stale value lingers
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge clk_i) fs_n_o = 1'b0;
    repeat (2) @(negedge clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      r[i] = sdo_i;
      sdi_o = w[i];
      sclk_o = 1'b1;
      @(negedge clk_i) sclk_o = 1'b0;
      @(negedge clk_i);
    end
    fs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // adcrst_host
`default_nettype wire

// *** sim/adcrst_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrst_tb_top
  import adcrst_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, fs_n, sclk, sdi, sdo, oe, ir, bsy, cv;
  logic [15:0] res = 16'h1234, rd;
  logic [11:0] cfg;
  int          mismatches = 0, n_tests = 0;
  always #10 clk = ~clk;
  adcrst_top adcrst_top_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .frame_sync_select_n_i(fs_n),
    .sclk_rise_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .result_i(res),
    .result_valid_i(1'b0), .config_register_o(cfg), .config_valid_o(cv),
    .internal_reset_o(ir), .busy_o(bsy));
  adcrst_host adcrst_host_inst (.clk_i(clk), .sdo_i(sdo), .fs_n_o(fs_n), .sclk_o(sclk), .sdi_o(sdi));
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task s_por;
    chk({4'h0, cfg}, 16'h0FFF);
    chk({15'h0, cv}, 16'h0001);
    adcrst_host_inst.xfer(16'h05A4, rd);
    chk(rd, 16'hFFFF);
    chk({4'h0, cfg}, 16'h05A4);
    adcrst_host_inst.xfer(16'h0AAA, rd);
    chk(rd, 16'h1234);
  endtask
  task s_soft;
    adcrst_host_inst.xfer(16'h0001, rd);
    chk({4'h0, cfg}, 16'h0FFF);
    chk({15'h0, bsy}, 16'h0000);
    adcrst_host_inst.xfer(16'h0F0E, rd);
    chk(rd, 16'hFFFF);
  endtask
  task s_hard;
    adcrst_host_inst.xfer(16'h0330, rd);
    chk(rd, 16'h1234);
    fork
      adcrst_host_inst.xfer(16'h0550, rd);
      begin
        repeat (8) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk) rst_n = 1'b1;
        chk({15'h0, ir}, 16'h0001);
        repeat (2) @(negedge clk);
        chk({15'h0, bsy}, 16'h0000);
      end
    join
    chk({4'h0, cfg}, {4'h0, CFG_RESET});
    adcrst_host_inst.xfer(16'h0330, rd);
    chk(rd, 16'hFFFF);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    s_por;
    s_soft;
    s_hard;
    finish_test;
  end
endmodule // adcrst_tb_top
`default_nettype wire
